// ---- hdl/piu_exec.sv ----
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "piu_cfg.svh"
// How it works
// RULE_01 - Writes change slots; read/probe change registers
// RULE_02 - Read replaces key tag with slot tag
// RULE_03 - TLB ops and wait need kernel or usable
// RULE_04 - Wait stops fetch and execution
// RULE_05 - Only reset or interrupt ends sleep
// RULE_06 - Unmasked wake traps at next instruction
// RULE_07 - Masked wake continues, interrupt stays pending
// RULE_08 - Service instruction always traps
// RULE_09 - Compare-swap is one locked memory operation
// RULE_10 - Store new word only on match
// RULE_11 - Result is one on update, else zero
// RULE_12 - Rejected op changes nothing before trap
// RULE_13 - Indexed write uses slot-pointer slot
// RULE_14 - Random write uses random-index slot
// RULE_15 - Probe loads slot or sets miss flag
// RULE_16 - Random index counts down, skips slot zero
module piu_exec #(
  parameter int ENTRY_COUNT = 16,
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic op_valid,
  output logic op_ready,
  input wire piu_pkg::piu_op_t op_code,
  input wire logic [31:0] op_pc,
  input wire logic [31:0] op_addr,
  input wire logic [31:0] op_expect,
  input wire logic [31:0] op_new,
  output logic done,
  output logic [31:0] resume_pc,
  output logic trap,
  output piu_pkg::piu_cause_t trap_cause,
  output logic [31:0] trap_epc,
  output logic cas_result,
  output logic fetch_stop,
  input wire logic irq_req,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic mem_lock,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack
);
  localparam int SLOT_W = `PIU_SLOT_W; // Slot field width
  localparam int STS_W = `PIU_STS_W; // Status field width
  localparam logic [SLOT_W-1:0] RND_TOP = SLOT_W'(ENTRY_COUNT - 1);

  // Refuse array sizes the slot field cannot reach
  if (ENTRY_COUNT < 2 || ENTRY_COUNT > (1 << SLOT_W)) begin : g_chk
    $error("ENTRY_COUNT out of range");
  end
  if (ADDR_W < 5) begin : g_chk_addr
    $error("ADDR_W too small");
  end

  // Whole module state
  typedef struct packed {
    piu_pkg::piu_state_t state; // Sequencer state
    logic [31:0] key; // TLB key register
    logic [31:0] val; // TLB value register
    logic [31:0] idx; // Slot-pointer register
    logic [SLOT_W-1:0] rnd; // Random slot index
    logic [`PIU_STS_W-1:0] sts; // Mode and mask bits
    logic irq_s1; // Interrupt sync, first stage
    logic irq_s2; // Interrupt sync, second stage
    logic done; // Completion pulse
    logic [31:0] resume_pc; // Next instruction address
    logic trap; // Trap pulse
    piu_pkg::piu_cause_t cause; // Trap cause
    logic [31:0] epc; // Trap location
    logic cas_res; // Last compare-swap outcome
    logic [31:0] pc; // Address of instruction in flight
    logic [31:0] cas_exp; // Expected word
    logic [31:0] cas_new; // Replacement word
    logic mem_req; // Memory request
    logic mem_we; // Memory write
    logic [31:0] mem_addr; // Memory address
    logic [31:0] mem_wdata; // Memory write data
    logic mem_lock; // Memory held for us
    logic aw_ok; // Write address held
    logic [ADDR_W-1:0] aw_addr; // Held write address
    logic w_ok; // Write data held
    logic [31:0] w_data; // Held write data
    logic [3:0] w_strb; // Held byte strobes
    logic bvalid; // Write answer pending
    logic [1:0] bresp; // Write answer code
    logic rvalid; // Read answer pending
    logic [31:0] rdata; // Read answer data
    logic [1:0] rresp; // Read answer code
  } piu_exec_st_t;
  piu_exec_st_t r; // Registered state
  piu_exec_st_t nxt; // Next state
  logic priv_ok; // Privileged ops allowed
  logic wr_go; // Bus write performed this cycle

  piu_tlb_if #(.SLOT_W(SLOT_W)) tlb_link ();

  // Translation array
  piu_tlb #(.ENTRY_COUNT(ENTRY_COUNT), .SLOT_W(SLOT_W)) u_tlb (
    .aclk(aclk),
    .aresetn(aresetn),
    .tlb(tlb_link.array)
  );

  // Register select from a bus address, 7 means unmapped
  function automatic logic [2:0] piu_sel(input logic [ADDR_W-1:0] a);
    unique case (8'(a))
      `PIU_KEY_OFS: piu_sel = 3'h0;
      `PIU_VAL_OFS: piu_sel = 3'h1;
      `PIU_IDX_OFS: piu_sel = 3'h2;
      `PIU_RND_OFS: piu_sel = 3'h3;
      `PIU_STS_OFS: piu_sel = 3'h4;
      `PIU_INFO_OFS: piu_sel = 3'h5;
      default: piu_sel = 3'h7;
    endcase
  endfunction : piu_sel

  // Byte-lane merge of a bus write
  function automatic logic [31:0] piu_merge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      piu_merge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction : piu_merge

  // RULE_03 privilege check
  assign priv_ok = r.sts[`PIU_ST_KERNEL] | r.sts[`PIU_ST_CU0];
  assign wr_go = r.aw_ok & r.w_ok & ~r.bvalid;

  // Next-state logic for sequencer, registers and bus
  always_comb begin
    nxt = r;
    nxt.irq_s1 = irq_req;
    nxt.irq_s2 = r.irq_s1;
    nxt.done = 1'h0;
    nxt.trap = 1'h0;
    // RULE_16 random index countdown
    nxt.rnd = (r.rnd <= SLOT_W'(1)) ? RND_TOP : r.rnd - SLOT_W'(1);
    tlb_link.we = 1'h0;
    // RULE_13 indexed slot selection
    tlb_link.wslot = r.idx[`PIU_SLOT_LSB +: SLOT_W];
    tlb_link.wkey = r.key;
    tlb_link.wval = r.val;
    tlb_link.rslot = r.idx[`PIU_SLOT_LSB +: SLOT_W];
    tlb_link.pkey = r.key;
    unique case (r.state)
      // Accept one instruction
      piu_pkg::st_ready: begin
        if (op_valid) begin
          nxt.pc = op_pc;
          nxt.done = 1'h1;
          nxt.resume_pc = op_pc + `PIU_PC_STEP;
          if (!priv_ok && (op_code != piu_pkg::system_service_trap_op) &&
              (op_code != piu_pkg::compare_swap_op)) begin
            // RULE_12 reject with no side effect
            nxt.done = 1'h0;
            nxt.trap = 1'h1;
            nxt.cause = piu_pkg::reserved_opcode_trap;
            nxt.epc = op_pc;
          end else begin
            unique case (op_code)
              // RULE_01 indexed write to array
              piu_pkg::tlb_write_indexed_op: begin
                tlb_link.we = 1'h1;
              end
              // RULE_14 random slot selection
              piu_pkg::tlb_write_random_op: begin
                tlb_link.we = 1'h1;
                tlb_link.wslot = r.rnd;
              end
              // RULE_02 whole key replaced, tag included
              piu_pkg::tlb_read_op: begin
                nxt.key = tlb_link.rkey;
                nxt.val = tlb_link.rval;
              end
              // RULE_15 probe result into slot pointer
              piu_pkg::tlb_probe_op: begin
                if (tlb_link.hit) begin
                  nxt.idx[`PIU_SLOT_LSB +: SLOT_W] = tlb_link.hslot;
                  nxt.idx[`PIU_PMISS_BIT] = 1'h0;
                end else begin
                  nxt.idx[`PIU_PMISS_BIT] = 1'h1;
                end
              end
              // RULE_04 enter sleep
              piu_pkg::idle_wait_op: begin
                nxt.done = 1'h0;
                nxt.state = piu_pkg::st_sleep;
              end
              // RULE_08 service trap in any mode
              piu_pkg::system_service_trap_op: begin
                nxt.done = 1'h0;
                nxt.trap = 1'h1;
                nxt.cause = piu_pkg::cause_service;
                nxt.epc = op_pc;
              end
              // RULE_09 start locked read
              piu_pkg::compare_swap_op: begin
                nxt.done = 1'h0;
                nxt.cas_exp = op_expect;
                nxt.cas_new = op_new;
                nxt.mem_req = 1'h1;
                nxt.mem_we = 1'h0;
                nxt.mem_addr = op_addr;
                nxt.mem_lock = 1'h1;
                nxt.state = piu_pkg::st_cas_read;
              end
              // Unused code traps as reserved
              default: begin
                nxt.done = 1'h0;
                nxt.trap = 1'h1;
                nxt.cause = piu_pkg::reserved_opcode_trap;
                nxt.epc = op_pc;
              end
            endcase
          end
        end
      end
      // Locked read returned
      piu_pkg::st_cas_read: begin
        if (mem_ack) begin
          nxt.mem_req = 1'h0;
          if (mem_rdata == r.cas_exp) begin
            // RULE_10 store only on match
            nxt.mem_req = 1'h1;
            nxt.mem_we = 1'h1;
            nxt.mem_wdata = r.cas_new;
            nxt.state = piu_pkg::st_cas_write;
          end else begin
            // RULE_11 no update gives zero
            nxt.cas_res = 1'h0;
            nxt.mem_lock = 1'h0;
            nxt.done = 1'h1;
            nxt.state = piu_pkg::st_ready;
          end
        end
      end
      // Locked write returned
      piu_pkg::st_cas_write: begin
        if (mem_ack) begin
          // RULE_11 update gives one
          nxt.cas_res = 1'h1;
          nxt.mem_req = 1'h0;
          nxt.mem_we = 1'h0;
          nxt.mem_lock = 1'h0;
          nxt.done = 1'h1;
          nxt.state = piu_pkg::st_ready;
        end
      end
      // RULE_05 sleep until interrupt
      piu_pkg::st_sleep: begin
        if (r.irq_s2) begin
          nxt.state = piu_pkg::st_ready;
          if (r.sts[`PIU_ST_UNMASK]) begin
            // RULE_06 trap at following instruction
            nxt.trap = 1'h1;
            nxt.cause = piu_pkg::cause_irq;
            nxt.epc = r.pc + `PIU_PC_STEP;
          end else begin
            // RULE_07 continue, interrupt left pending
            nxt.done = 1'h1;
            nxt.resume_pc = r.pc + `PIU_PC_STEP;
          end
        end
      end
      default: begin
        nxt.state = piu_pkg::st_ready;
      end
    endcase
    // Bus address and data capture
    if (s_axi_awvalid && !r.aw_ok) begin
      nxt.aw_ok = 1'h1;
      nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_ok) begin
      nxt.w_ok = 1'h1;
      nxt.w_data = s_axi_wdata;
      nxt.w_strb = s_axi_wstrb;
    end
    // Bus write, applied after instruction updates
    if (wr_go) begin
      nxt.aw_ok = 1'h0;
      nxt.w_ok = 1'h0;
      nxt.bvalid = 1'h1;
      nxt.bresp = `PIU_RESP_OKAY;
      unique case (piu_sel(r.aw_addr))
        3'h0: nxt.key = piu_merge(r.key, r.w_data, r.w_strb);
        3'h1: nxt.val = piu_merge(r.val, r.w_data, r.w_strb);
        3'h2: nxt.idx = piu_merge(r.idx, r.w_data, r.w_strb);
        3'h4: nxt.sts = STS_W'(piu_merge(32'(r.sts), r.w_data,
          r.w_strb));
        3'h3, 3'h5: nxt.bresp = `PIU_RESP_OKAY;
        default: nxt.bresp = `PIU_RESP_SLVERR;
      endcase
    end else if (r.bvalid && s_axi_bready) begin
      nxt.bvalid = 1'h0;
    end
    // Bus read
    if (s_axi_arvalid && !r.rvalid) begin
      nxt.rvalid = 1'h1;
      nxt.rresp = `PIU_RESP_OKAY;
      unique case (piu_sel(s_axi_araddr))
        3'h0: nxt.rdata = r.key;
        3'h1: nxt.rdata = r.val;
        3'h2: nxt.rdata = r.idx;
        3'h3: nxt.rdata = 32'(r.rnd) << `PIU_SLOT_LSB;
        3'h4: nxt.rdata = 32'(r.sts);
        3'h5: nxt.rdata = 32'({r.cas_res, r.state == piu_pkg::st_sleep});
        default: begin
          nxt.rdata = 32'h0;
          nxt.rresp = `PIU_RESP_SLVERR;
        end
      endcase
    end else if (r.rvalid && s_axi_rready) begin
      nxt.rvalid = 1'h0;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.state <= piu_pkg::st_ready;
      r.rnd <= RND_TOP;
      r.sts <= `PIU_STS_RST;
      r.cause <= piu_pkg::cause_none;
    end else begin
      r <= nxt;
    end
  end

  // Outputs
  assign s_axi_awready = ~r.aw_ok;
  assign s_axi_wready = ~r.w_ok;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = ~r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign op_ready = (r.state == piu_pkg::st_ready);
  assign done = r.done;
  assign resume_pc = r.resume_pc;
  assign trap = r.trap;
  assign trap_cause = r.cause;
  assign trap_epc = r.epc;
  assign cas_result = r.cas_res;
  assign fetch_stop = (r.state == piu_pkg::st_sleep);
  assign mem_req = r.mem_req;
  assign mem_we = r.mem_we;
  assign mem_addr = r.mem_addr;
  assign mem_wdata = r.mem_wdata;
  assign mem_lock = r.mem_lock;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Accepted op by kind
  sequence s_take(piu_pkg::piu_op_t k);
    op_ready && op_valid && op_code == k;
  endsequence
  sequence s_cas_hit;
    r.state == piu_pkg::st_cas_read && mem_ack && mem_rdata == r.cas_exp;
  endsequence
  // RULE_04 wait puts core to sleep
  a_wait_sleeps: assert property ( // RULE_04
    s_take(piu_pkg::idle_wait_op) and priv_ok |=> fetch_stop && !done)
    else $error("wait did not stop fetch");
  // RULE_05 sleep holds without interrupt
  a_sleep_holds: assert property ( // RULE_05
    fetch_stop && !r.irq_s2 |=> fetch_stop)
    else $error("sleep ended without interrupt");
  // RULE_06 unmasked wake trap location
  a_wake_trap: assert property ( // RULE_06
    fetch_stop && r.irq_s2 && r.sts[`PIU_ST_UNMASK] |=>
      trap && trap_cause == piu_pkg::cause_irq &&
      trap_epc == $past(r.pc) + `PIU_PC_STEP)
    else $error("unmasked wake trapped wrong");
  // RULE_07 masked wake continues
  a_wake_cont: assert property ( // RULE_07
    fetch_stop && r.irq_s2 && !r.sts[`PIU_ST_UNMASK] |=>
      done && !trap && resume_pc == $past(r.pc) + `PIU_PC_STEP)
    else $error("masked wake did not continue");
  // RULE_08 service trap always
  a_service: assert property ( // RULE_08
    s_take(piu_pkg::system_service_trap_op) |=>
      trap && trap_cause == piu_pkg::cause_service)
    else $error("service op did not trap");
  // RULE_12 rejected op leaves registers alone
  a_reject: assert property ( // RULE_12
    s_take(piu_pkg::tlb_read_op) and !priv_ok and !wr_go |=>
      trap && trap_cause == piu_pkg::reserved_opcode_trap &&
      $stable(r.key) && $stable(r.val))
    else $error("rejected op changed state");
  // RULE_10 match leads to locked write of new word
  a_cas_store: assert property ( // RULE_10
    s_cas_hit |=> mem_req && mem_we && mem_lock &&
      mem_wdata == r.cas_new ##1 mem_lock)
    else $error("compare-swap store wrong");
  // RULE_11 mismatch answers zero without a write
  a_cas_miss: assert property ( // RULE_11
    r.state == piu_pkg::st_cas_read && mem_ack &&
      mem_rdata != r.cas_exp |=> done && !cas_result && !mem_we)
    else $error("compare-swap mismatch wrong");
  // RULE_16 random index range and wrap
  a_rnd_wrap: assert property ( // RULE_16
    r.rnd == SLOT_W'(1) |=> r.rnd == RND_TOP && r.rnd != '0)
    else $error("random index did not wrap");
  // RULE_15 probe hit loads slot
  a_probe_hit: assert property ( // RULE_15
    s_take(piu_pkg::tlb_probe_op) and priv_ok and tlb_link.hit
      and !wr_go |=> !r.idx[`PIU_PMISS_BIT] &&
      r.idx[`PIU_SLOT_LSB +: SLOT_W] == $past(tlb_link.hslot))
    else $error("probe hit not loaded");
endmodule : piu_exec

// ---- hdl/piu_tlb.sv ----
`timescale 1ns/1ps
`include "piu_cfg.svh"
// Translation array with combinational read and search
module piu_tlb #(
  parameter int ENTRY_COUNT = 16,
  parameter int SLOT_W = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  piu_tlb_if.array tlb
);
  // All slots, key in the upper word
  typedef struct packed {
    logic [ENTRY_COUNT-1:0][63:0] ent;
  } piu_tlb_st_t;
  piu_tlb_st_t r; // Registered state
  piu_tlb_st_t nxt; // Next state

  // Key match on page number and address-space tag
  function automatic logic piu_match(input logic [31:0] a,
      input logic [31:0] b);
    piu_match = (a[31:`PIU_VPN_LSB] == b[31:`PIU_VPN_LSB]) &&
      (a[`PIU_TAG_MSB:`PIU_TAG_LSB] == b[`PIU_TAG_MSB:`PIU_TAG_LSB]);
  endfunction : piu_match

  // Slot update on a write strobe
  always_comb begin
    nxt = r;
    if (tlb.we && (int'(tlb.wslot) < ENTRY_COUNT)) begin
      nxt.ent[tlb.wslot] = {tlb.wkey, tlb.wval};
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  // Read port, out of range reads zero
  always_comb begin
    tlb.rkey = 32'h0;
    tlb.rval = 32'h0;
    if (int'(tlb.rslot) < ENTRY_COUNT) begin
      tlb.rkey = r.ent[tlb.rslot][63:32];
      tlb.rval = r.ent[tlb.rslot][31:0];
    end
  end

  // Search, lowest matching slot wins
  always_comb begin
    tlb.hit = 1'h0;
    tlb.hslot = '0;
    for (int i = ENTRY_COUNT - 1; i >= 0; i--) begin
      if (piu_match(r.ent[i][63:32], tlb.pkey)) begin
        tlb.hit = 1'h1;
        tlb.hslot = SLOT_W'(i);
      end
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // RULE_01 write lands in slot
  a_write_lands: assert property ( // RULE_01
    tlb.we && (int'(tlb.wslot) < ENTRY_COUNT) |=>
      r.ent[$past(tlb.wslot)] == {$past(tlb.wkey), $past(tlb.wval)})
    else $error("tlb write did not land in its slot");
endmodule : piu_tlb

// ---- pkg/piu_cfg.svh ----
`ifndef PIU_CFG_SVH
`define PIU_CFG_SVH
// Register byte offsets on the control bus
`define PIU_KEY_OFS 8'h00
`define PIU_VAL_OFS 8'h04
`define PIU_IDX_OFS 8'h08
`define PIU_RND_OFS 8'h0c
`define PIU_STS_OFS 8'h10
`define PIU_INFO_OFS 8'h14
// Slot field layout in slot-pointer and random-index registers
`define PIU_SLOT_W 6
`define PIU_SLOT_LSB 8
// Probe-miss flag in the slot-pointer register
`define PIU_PMISS_BIT 31
// Key register layout: page number and address-space tag
`define PIU_VPN_LSB 12
`define PIU_TAG_LSB 6
`define PIU_TAG_MSB 11
// Status register bits
`define PIU_ST_KERNEL 0
`define PIU_ST_CU0 1
`define PIU_ST_UNMASK 2
`define PIU_STS_W 3
`define PIU_STS_RST 3'h1
// Info register bits
`define PIU_INFO_SLEEP 0
`define PIU_INFO_CAS 1
// Instruction step and bus answers
`define PIU_PC_STEP 32'h0000_0004
`define PIU_RESP_OKAY 2'h0
`define PIU_RESP_SLVERR 2'h2
`endif

// ---- pkg/piu_pkg.sv ----
package piu_pkg;
  // Instructions handed over by issue
  typedef enum logic [2:0] {
    tlb_write_indexed_op = 3'h0,
    tlb_write_random_op = 3'h1,
    tlb_read_op = 3'h2,
    tlb_probe_op = 3'h3,
    idle_wait_op = 3'h4,
    system_service_trap_op = 3'h5,
    compare_swap_op = 3'h6
  } piu_op_t;
  // Trap causes reported to the core
  typedef enum logic [1:0] {
    cause_none = 2'h0,
    reserved_opcode_trap = 2'h1,
    cause_service = 2'h2,
    cause_irq = 2'h3
  } piu_cause_t;
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    st_ready = 4'h1,
    st_cas_read = 4'h2,
    st_cas_write = 4'h4,
    st_sleep = 4'h8
  } piu_state_t;
endpackage : piu_pkg

// ---- pkg/piu_tlb_if.sv ----
`timescale 1ns/1ps
// Link between the sequencer and the translation array
interface piu_tlb_if #(parameter int SLOT_W = 6);
  logic we; // Write strobe
  logic [SLOT_W-1:0] wslot; // Slot written
  logic [31:0] wkey; // Key word written
  logic [31:0] wval; // Value word written
  logic [SLOT_W-1:0] rslot; // Slot read
  logic [31:0] rkey; // Key word read
  logic [31:0] rval; // Value word read
  logic [31:0] pkey; // Key searched
  logic hit; // Search found a slot
  logic [SLOT_W-1:0] hslot; // Slot that matched
  modport core (output we, wslot, wkey, wval, rslot, pkey,
    input rkey, rval, hit, hslot);
  modport array (input we, wslot, wkey, wval, rslot, pkey,
    output rkey, rval, hit, hslot);
endinterface : piu_tlb_if

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
// Compare one value and count it
`define CHK(n,e,a) begin check_count++; if ((a)!==(e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, op_valid = 0, irq_req = 0, mem_ack = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, op_pc = 0, op_expect = 0, op_new = 0;
  logic [31:0] mem_rdata = 0, mem_w = 32'h5, d, resume_pc, trap_epc;
  logic [31:0] rdata, mem_addr, mem_wdata;
  logic awready, wready, bvalid, arready, rvalid, op_ready, done, trap;
  logic cas_result, fetch_stop, mem_req, mem_we, mem_lock, lock_bad = 0;
  logic [1:0] bresp, rresp, rs;
  piu_pkg::piu_op_t op_code = piu_pkg::tlb_read_op;
  piu_pkg::piu_cause_t trap_cause;
  int error_cnt = 0, check_count = 0, wr_cnt = 0;
  localparam logic [31:0] K = 32'h0001_2040, V = 32'h0000_a500;
  piu_exec #(.ENTRY_COUNT(16), .ADDR_W(8)) i_dut (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
    .op_pc(op_pc), .op_addr(32'h40), .op_expect(op_expect),
    .op_new(op_new), .done(done), .resume_pc(resume_pc), .trap(trap),
    .trap_cause(trap_cause), .trap_epc(trap_epc), .cas_result(cas_result),
    .fetch_stop(fetch_stop), .irq_req(irq_req), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_lock(mem_lock), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  // Clock of 100 ns period
  initial forever #50 aclk = ~aclk;
  // One-word memory, answers each request after one cycle
  always @(posedge aclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_lock) lock_bad <= 1'b1;
    if (mem_req && !mem_ack) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_w;
      if (mem_we) begin
        mem_w <= mem_wdata;
        wr_cnt <= wr_cnt + 1;
      end
    end
  end
  // Counts and verdict
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // A wait ran out
  task to;
    error_cnt++;
    $display("MISMATCH wait exp done got timeout");
    wrap_up();
  endtask : to
  // Bus write, response code left in rs
  task wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic ka, kw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      if (bvalid) begin
        rs = bresp;
        @(posedge aclk);
        bready <= 1'b0;
        break;
      end
      ka = awready;
      kw = wready;
      @(posedge aclk);
      if (ka) awvalid <= 1'b0;
      if (kw) wvalid <= 1'b0;
    end
    if (n == 40) to();
  endtask : wr
  // Bus read into d and rs
  task rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      if (rvalid) begin
        d = rdata;
        rs = rresp;
        @(posedge aclk);
        rready <= 1'b0;
        break;
      end
      if (arready) begin
        @(posedge aclk);
        arvalid <= 1'b0;
      end
    end
    if (n == 40) to();
  endtask : rd
  // Hand one instruction over; returns at the edge that took it
  task op(input piu_pkg::piu_op_t c, input logic [31:0] pc);
    int n;
    @(posedge aclk);
    op_code <= c;
    op_pc <= pc;
    op_valid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      if (op_ready === 1'b1) break;
    end
    @(posedge aclk);
    op_valid <= 1'b0;
    if (n == 40) to();
  endtask : op
  // Wait for the completion or trap pulse
  task wt;
    int n;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      if (done === 1'b1 || trap === 1'b1) break;
    end
    if (n == 40) to();
  endtask : wt
  task t_reset;
    rd(8'h10); `CHK("status", 32'h1, d)
    rd(8'h0c); `CHK("rnd", 1'b1, d[13:8] >= 1 && d[13:8] <= 15)
    rd(8'h18); `CHK("rresp", 2'h2, rs)
    wr(8'h18, 32'h1); `CHK("bresp", 2'h2, rs)
    $display("t_reset end");
  endtask : t_reset
  task t_tlb;
    wr(8'h00, K);
    wr(8'h04, V);
    wr(8'h08, 32'h300);
    op(piu_pkg::tlb_write_indexed_op, 0);
    wt; `CHK("wi", 1'b1, done)
    wr(8'h00, 0);
    op(piu_pkg::tlb_read_op, 0); wt;
    rd(8'h00); `CHK("key", K, d)
    rd(8'h04); `CHK("val", V, d)
    op(piu_pkg::tlb_probe_op, 0); wt;
    rd(8'h08); `CHK("hit", 32'h300, d & 32'h8000_3f00)
    wr(8'h00, 32'h0009_9000);
    op(piu_pkg::tlb_probe_op, 0); wt;
    rd(8'h08); `CHK("miss", 1'b1, d[31])
    op(piu_pkg::tlb_write_random_op, 0); wt;
    op(piu_pkg::tlb_probe_op, 0); wt;
    rd(8'h08); `CHK("rslot", 1'b1, !d[31] && d[13:8] != 0)
    $display("t_tlb end");
  endtask : t_tlb
  task t_priv;
    wr(8'h10, 0);
    wr(8'h00, 32'h77);
    op(piu_pkg::tlb_read_op, 32'h40); wt;
    `CHK("cause", piu_pkg::reserved_opcode_trap, trap_cause)
    `CHK("epc", 32'h40, trap_epc)
    rd(8'h00); `CHK("key kept", 32'h77, d)
    op(piu_pkg::system_service_trap_op, 32'h80); wt;
    `CHK("svc", piu_pkg::cause_service, trap_cause)
    wr(8'h10, 32'h2);
    op(piu_pkg::tlb_probe_op, 0); wt; `CHK("cu0", 1'b1, done)
    wr(8'h10, 32'h1);
    $display("t_priv end");
  endtask : t_priv
  task t_wait;
    int n;
    wr(8'h10, 32'h5);
    op(piu_pkg::idle_wait_op, 32'h100);
    @(negedge aclk); `CHK("stop", 1'b1, fetch_stop)
    n = 0;
    repeat (6) @(negedge aclk) n += (done | trap | op_ready);
    `CHK("asleep", 0, n)
    @(posedge aclk);
    irq_req <= 1'b1;
    wt; `CHK("irq", piu_pkg::cause_irq, trap_cause)
    `CHK("irq epc", 32'h104, trap_epc)
    @(posedge aclk);
    irq_req <= 1'b0;
    wr(8'h10, 32'h1);
    op(piu_pkg::idle_wait_op, 32'h200);
    repeat (3) @(negedge aclk);
    @(posedge aclk);
    irq_req <= 1'b1;
    wt; `CHK("masked", 1'b1, done)
    `CHK("resume", 32'h204, resume_pc)
    @(posedge aclk);
    irq_req <= 1'b0;
    $display("t_wait end");
  endtask : t_wait
  task t_cas;
    @(posedge aclk);
    op_expect <= 32'h5;
    op_new <= 32'h9;
    op(piu_pkg::compare_swap_op, 0);
    wt; `CHK("res1", 1'b1, cas_result)
    `CHK("mem new", 32'h9, mem_w)
    `CHK("addr", 32'h40, mem_addr)
    op(piu_pkg::compare_swap_op, 0);
    wt; `CHK("res0", 1'b0, cas_result)
    `CHK("writes", 1, wr_cnt)
    `CHK("lock", 1'b0, lock_bad)
    $display("t_cas end");
  endtask : t_cas
  // Reset for 16 cycles, then the scenarios
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_tlb();
    t_priv();
    t_wait();
    t_cas();
    wrap_up();
  end
endmodule : tb_top
